// file: rtl/aai_intc.sv
// Audio converter interrupt logic: config, mask and latch registers with pin drive
`timescale 1ns/1ps
`default_nettype none
`include "aai_params.svh"

module aai_intc
#(
	parameter int PULSE_CYC = `AAI_PULSE_MS * `AAI_CLK_KHZ,
	parameter int PERIOD_CYC = `AAI_PERIOD_MS * `AAI_CLK_KHZ
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Register access from the control port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	// Event sources, one-cycle pulses, bit 4 maps latch bit 7
	input wire logic serial_audio_port_clk_err,
	input wire logic pll_lock,
	input wire logic mix_saturation,
	input wire logic voice_activity_up,
	input wire logic voice_activity_down,
	// Interrupt pin
	output logic int_pin_ff
);
	import aai_pkg::*;

	localparam int EVW = `AAI_EV_MSB - `AAI_EV_LSB + 1;

	// ==========================================
	// Decode shared by write, read and clear
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
		hit = (addr == target);
	endfunction

	aai_cfg_t cfg_ff;
	aai_cfg_t nxt_cfg;
	logic [7:0] event_mask_ff;
	logic [7:0] nxt_event_mask;
	logic [EVW-1:0] event_latch_ff;
	logic [EVW-1:0] nxt_event_latch;
	logic [7:0] nxt_reg_rdata;
	logic nxt_int_pin;
	logic [EVW-1:0] ev_in;
	logic [EVW-1:0] ev_enabled;
	logic [EVW-1:0] latch_view;

	aai_pin_if pin_link();

	// ==========================================
	// Event mapping
	assign ev_in[`AAI_EV_SERIAL_CLK - `AAI_EV_LSB] = serial_audio_port_clk_err;
	assign ev_in[`AAI_EV_PLL_LOCK - `AAI_EV_LSB] = pll_lock;
	assign ev_in[`AAI_EV_MIX_SAT - `AAI_EV_LSB] = mix_saturation;
	assign ev_in[`AAI_EV_VOICE_UP - `AAI_EV_LSB] = voice_activity_up;
	assign ev_in[`AAI_EV_VOICE_DOWN - `AAI_EV_LSB] = voice_activity_down;

	// Zero in a mask bit enables that event
	assign ev_enabled = ~event_mask_ff[`AAI_EV_MSB:`AAI_EV_LSB];

	// ==========================================
	// Configuration and mask registers
	always_comb
	begin
		nxt_cfg = cfg_ff;
		nxt_event_mask = event_mask_ff;
		if (reg_wr && hit(reg_addr, `AAI_ADDR_CFG))
		begin
			// Reserved config bits are not stored, so they always read back zero
			nxt_cfg.pin_polarity = reg_wdata[`AAI_CFG_POL];
			nxt_cfg.mode = aai_mode_t'(reg_wdata[`AAI_CFG_MODE_HI:`AAI_CFG_MODE_LO]);
			nxt_cfg.readback_config = reg_wdata[`AAI_CFG_RB];
		end
		if (reg_wr && hit(reg_addr, `AAI_ADDR_MASK))
		begin
			// Low reserved bits are stored as written; software keeps them at one
			nxt_event_mask = reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cfg_ff <= aai_cfg_t'(4'h0);
			event_mask_ff <= `AAI_MASK_RST;
		end
		else
		begin
			cfg_ff <= nxt_cfg;
			event_mask_ff <= nxt_event_mask;
		end
	end

	// ==========================================
	// Event latch
	generate
		for (genvar i = 0; i < EVW; i++)
		begin : g_latch
			always_comb
			begin
				nxt_event_latch[i] = event_latch_ff[i];
				// Whole register clears on read, masked bits too
				if (reg_rd && hit(reg_addr, `AAI_ADDR_LATCH))
				begin
					nxt_event_latch[i] = 1'b0;
				end
				// An event in the read cycle survives the clear
				if (ev_in[i])
				begin
					nxt_event_latch[i] = 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			event_latch_ff <= `AAI_LATCH_RST;
		end
		else
		begin
			event_latch_ff <= nxt_event_latch;
		end
	end

	// ==========================================
	// Read data
	assign latch_view = cfg_ff.readback_config ? (event_latch_ff & ev_enabled) : event_latch_ff;

	always_comb
	begin
		nxt_reg_rdata = reg_rdata_ff;
		if (reg_rd)
		begin
			if (hit(reg_addr, `AAI_ADDR_CFG))
			begin
				nxt_reg_rdata = {cfg_ff.pin_polarity, cfg_ff.mode, 2'h0, cfg_ff.readback_config, 2'h0};
			end
			else if (hit(reg_addr, `AAI_ADDR_MASK))
			begin
				nxt_reg_rdata = event_mask_ff;
			end
			else if (hit(reg_addr, `AAI_ADDR_LATCH))
			begin
				nxt_reg_rdata = {latch_view, 3'h0};
			end
			else
			begin
				nxt_reg_rdata = 8'h00;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata_ff <= `AAI_RDATA_RST;
		end
		else
		begin
			reg_rdata_ff <= nxt_reg_rdata;
		end
	end

	// ==========================================
	// Pin request and shaping
	assign pin_link.mode = cfg_ff.mode;
	assign pin_link.level_req = |(event_latch_ff & ev_enabled);
	assign pin_link.new_event = |(ev_in & ev_enabled);

	aai_pin_shaper
	#(
		.PULSE_CYC(PULSE_CYC),
		.PERIOD_CYC(PERIOD_CYC)
	)
	u_shaper
	(
		.clk(clk),
		.nrst(nrst),
		.pin(pin_link.shaper)
	);

	// Registered so the pin never glitches on a mode or polarity change
	assign nxt_int_pin = cfg_ff.pin_polarity ? pin_link.active : !pin_link.active;

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			int_pin_ff <= 1'b1;
		end
		else
		begin
			int_pin_ff <= nxt_int_pin;
		end
	end

	// ==========================================
	// Checks
	latch_set_a: assert property (@(posedge clk) disable iff (!nrst)
		(|ev_in) |=> ((event_latch_ff & $past(ev_in)) == $past(ev_in)))
		else $error("event not latched");

	read_clear_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_LATCH && ev_in == '0) |=> (event_latch_ff == '0))
		else $error("latch not cleared by read");

	mask_write_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_wr && reg_addr == `AAI_ADDR_MASK) |=> (event_mask_ff == $past(reg_wdata)))
		else $error("mask write lost");

	raw_readback_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_LATCH && !cfg_ff.readback_config)
		|=> (reg_rdata_ff == {$past(event_latch_ff), 3'h0}))
		else $error("latch readback not raw");

	masked_readback_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_LATCH && cfg_ff.readback_config)
		|=> (reg_rdata_ff[7:3] == ($past(event_latch_ff) & ~$past(event_mask_ff[7:3]))))
		else $error("masked event visible in readback");

	latch_low_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_LATCH) |=> (reg_rdata_ff[2:0] == 3'h0))
		else $error("latch low bits not zero");

	cfg_reserved_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_CFG) |=> (reg_rdata_ff[4:3] == 2'h0 && reg_rdata_ff[1:0] == 2'h0))
		else $error("config reserved bits not zero");

	level_pin_a: assert property (@(posedge clk) disable iff (!nrst)
		(cfg_ff.mode == AAI_MODE_LEVEL)
		|=> (int_pin_ff == ($past(cfg_ff.pin_polarity) ? $past(pin_link.level_req) : !$past(pin_link.level_req))))
		else $error("level mode pin wrong");

	pin_polarity_a: assert property (@(posedge clk) disable iff (!nrst)
		(!pin_link.active && cfg_ff.pin_polarity) |=> !int_pin_ff)
		else $error("idle active-high pin asserted");

	cfg_write_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_wr && reg_addr == `AAI_ADDR_CFG)
		|=> (cfg_ff.pin_polarity == $past(reg_wdata[`AAI_CFG_POL])
		&& cfg_ff.mode == aai_mode_t'($past(reg_wdata[`AAI_CFG_MODE_HI:`AAI_CFG_MODE_LO]))
		&& cfg_ff.readback_config == $past(reg_wdata[`AAI_CFG_RB])))
		else $error("config write lost");

	mask_read_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_MASK) |=> (reg_rdata_ff == $past(event_mask_ff)))
		else $error("mask readback wrong");

	cfg_read_a: assert property (@(posedge clk) disable iff (!nrst)
		(reg_rd && reg_addr == `AAI_ADDR_CFG)
		|=> (reg_rdata_ff[`AAI_CFG_POL] == $past(cfg_ff.pin_polarity)
		&& reg_rdata_ff[`AAI_CFG_RB] == $past(cfg_ff.readback_config)))
		else $error("config readback wrong");

	clk_err_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		serial_audio_port_clk_err |=> event_latch_ff[`AAI_EV_SERIAL_CLK - `AAI_EV_LSB])
		else $error("clock error not latched");

	pll_lock_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		pll_lock |=> event_latch_ff[`AAI_EV_PLL_LOCK - `AAI_EV_LSB])
		else $error("lock event not latched");

	saturation_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		mix_saturation |=> event_latch_ff[`AAI_EV_MIX_SAT - `AAI_EV_LSB])
		else $error("saturation event not latched");

	voice_up_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		voice_activity_up |=> event_latch_ff[`AAI_EV_VOICE_UP - `AAI_EV_LSB])
		else $error("voice up event not latched");

	voice_down_latch_a: assert property (@(posedge clk) disable iff (!nrst)
		voice_activity_down |=> event_latch_ff[`AAI_EV_VOICE_DOWN - `AAI_EV_LSB])
		else $error("voice down event not latched");

	latch_hold_a: assert property (@(posedge clk) disable iff (!nrst)
		(!(reg_rd && reg_addr == `AAI_ADDR_LATCH) && ev_in == '0) |=> $stable(event_latch_ff))
		else $error("latch changed without event or read");

	mode_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		(cfg_ff.mode == AAI_MODE_UNUSED) |=> (int_pin_ff == !$past(cfg_ff.pin_polarity)))
		else $error("reserved mode drove the pin");

	repeat_idle_a: assert property (@(posedge clk) disable iff (!nrst)
		(cfg_ff.mode == AAI_MODE_REPEAT && !pin_link.level_req) |=> (int_pin_ff == !$past(cfg_ff.pin_polarity)))
		else $error("repeating mode pin active without request");

	single_start_a: assert property (@(posedge clk) disable iff (!nrst)
		(cfg_ff.mode == AAI_MODE_SINGLE && pin_link.new_event) ##1 (cfg_ff.mode == AAI_MODE_SINGLE)
		|=> (int_pin_ff == $past(cfg_ff.pin_polarity)))
		else $error("single pulse missing on pin");

endmodule

`default_nettype wire

// file: rtl/aai_params.svh
// Offsets, field positions, reset values and timing figures of the audio interrupt logic
`ifndef AAI_PARAMS_SVH
`define AAI_PARAMS_SVH

// ==========================================
// Register offsets
`define AAI_ADDR_CFG 8'h32
`define AAI_ADDR_MASK 8'h33
`define AAI_ADDR_LATCH 8'h36

// ==========================================
// Reset values
`define AAI_CFG_RST 8'h00
`define AAI_MASK_RST 8'hFF
`define AAI_LATCH_RST 5'h00
`define AAI_RDATA_RST 8'h00

// ==========================================
// Field positions
`define AAI_CFG_POL 7
`define AAI_CFG_MODE_HI 6
`define AAI_CFG_MODE_LO 5
`define AAI_CFG_RB 2
`define AAI_EV_MSB 7
`define AAI_EV_LSB 3
`define AAI_EV_SERIAL_CLK 7
`define AAI_EV_PLL_LOCK 6
`define AAI_EV_MIX_SAT 5
`define AAI_EV_VOICE_UP 4
`define AAI_EV_VOICE_DOWN 3

// ==========================================
// Timing
`define AAI_CLK_KHZ 40000
`define AAI_PULSE_MS 2
`define AAI_PERIOD_MS 4

`endif

// file: rtl/aai_pin_if.sv
// Link between the register core and the interrupt pin shaper
`timescale 1ns/1ps
`default_nettype none

interface aai_pin_if;
	import aai_pkg::*;

	aai_mode_t mode;
	logic level_req;
	logic new_event;
	logic active;

	modport core
	(
		output mode,
		output level_req,
		output new_event,
		input active
	);

	modport shaper
	(
		input mode,
		input level_req,
		input new_event,
		output active
	);
endinterface

`default_nettype wire

// file: rtl/aai_pin_shaper.sv
// Interrupt pin shaper: level, repeating pulse and single pulse
`timescale 1ns/1ps
`default_nettype none

module aai_pin_shaper
#(
	parameter int PULSE_CYC = 80000,
	parameter int PERIOD_CYC = 160000
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Core side
	aai_pin_if.shaper pin
);
	import aai_pkg::*;

	localparam int CW = $clog2(PERIOD_CYC + 1);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;

	// ==========================================
	// Pulse timer
	always_comb
	begin
		nxt_cnt = '0;
		pin.active = 1'b0;
		unique case (pin.mode)
			AAI_MODE_LEVEL:
			begin
				pin.active = pin.level_req;
			end
			AAI_MODE_UNUSED:
			begin
				pin.active = 1'b0;
			end
			AAI_MODE_REPEAT:
			begin
				// Timer restarts whenever the request falls, so each burst opens with a full pulse
				if (pin.level_req)
				begin
					nxt_cnt = (cnt_ff == CW'(PERIOD_CYC - 1)) ? '0 : cnt_ff + CW'(1);
				end
				pin.active = pin.level_req && (cnt_ff < CW'(PULSE_CYC));
			end
			AAI_MODE_SINGLE:
			begin
				// A new event during a pulse stretches it rather than adding a gap
				if (pin.new_event)
				begin
					nxt_cnt = CW'(PULSE_CYC);
				end
				else if (cnt_ff != '0)
				begin
					nxt_cnt = cnt_ff - CW'(1);
				end
				pin.active = (cnt_ff != '0);
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt_ff <= '0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
		end
	end

	// ==========================================
	// Checks
	single_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		(pin.mode == AAI_MODE_SINGLE && pin.new_event) ##1 (pin.mode == AAI_MODE_SINGLE) |-> pin.active [*4])
		else $error("single pulse did not start");

	repeat_gap_a: assert property (@(posedge clk) disable iff (!nrst)
		(pin.mode == AAI_MODE_REPEAT && cnt_ff >= CW'(PULSE_CYC)) |-> !pin.active)
		else $error("repeating pulse active in its off half");

endmodule

`default_nettype wire

// file: rtl/aai_pkg.sv
// Types shared by the audio interrupt logic
package aai_pkg;

	// ==========================================
	// Event mode field encoding
	typedef enum logic [1:0]
	{
		AAI_MODE_LEVEL = 2'h0,
		AAI_MODE_UNUSED = 2'h1,
		AAI_MODE_REPEAT = 2'h2,
		AAI_MODE_SINGLE = 2'h3
	} aai_mode_t;

	// ==========================================
	// Stored configuration fields
	typedef struct packed
	{
		logic pin_polarity;
		aai_mode_t mode;
		logic readback_config;
	} aai_cfg_t;

endpackage

// file: tb/aai_host_model.sv
// Host processor model driving the control port of the interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "aai_params.svh"

module aai_host_model
(
	// Clock
	input wire logic clk,
	// Control port
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata_ff
);
	// =====
	// Idle bus
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// =====
	// Bus cycles, driven on the falling edge
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] d;
		d = data;
		if (addr == `AAI_ADDR_MASK)
			d[2:0] = 3'h7;
		if (addr == `AAI_ADDR_CFG)
			d = d & 8'hE4;
		@(negedge clk);
		reg_addr = addr;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		// Released lines show junk, not the old value
		reg_wdata = ~d;
		reg_addr = ~addr;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(negedge clk);
		reg_addr = addr;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~addr;
		data = reg_rdata_ff;
	endtask
endmodule

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench of the audio interrupt logic
`timescale 1ns/1ps
`default_nettype none
`include "aai_params.svh"

module testbench;
	import aai_pkg::*;

	typedef struct packed
	{
		logic [7:0] cfg;
		logic [7:0] mask;
		logic [4:0] ev;
		logic [7:0] latch;
		logic pin;
	} aai_row_t;

	logic clk;
	logic nrst;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] rdata;
	logic [4:0] ev;
	logic pin;
	logic [7:0] d;
	logic [7:0] n;
	int failures;
	int compares;
	aai_row_t rows [5] = '{
		'{8'h00, 8'h7F, 5'h10, 8'h80, 1'b0},
		'{8'h80, 8'hBF, 5'h08, 8'h40, 1'b1},
		'{8'h00, 8'hFF, 5'h04, 8'h20, 1'b1},
		'{8'h04, 8'hEF, 5'h03, 8'h10, 1'b0},
		'{8'h84, 8'hFF, 5'h1F, 8'h00, 1'b0}};

	// =====
	// Design and host model
	aai_intc #(.PULSE_CYC(8), .PERIOD_CYC(16)) DUT
	(
		.clk(clk),
		.nrst(nrst),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata_ff(rdata),
		.serial_audio_port_clk_err(ev[4]),
		.pll_lock(ev[3]),
		.mix_saturation(ev[2]),
		.voice_activity_up(ev[1]),
		.voice_activity_down(ev[0]),
		.int_pin_ff(pin)
	);

	aai_host_model host
	(
		.clk(clk),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata_ff(rdata)
	);

	// =====
	// Clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		// Tests need well under 1000 cycles
		#(25 * 4000);
		failures++;
		complete_run();
	end

	// =====
	// Helpers
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
			$display("Error at %0t: byte %h expected %h", $time, got, exp);
		if (got !== exp)
			failures++;
	endtask

	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp)
			$display("Error at %0t: pin %b expected %b", $time, got, exp);
		if (got !== exp)
			failures++;
	endtask

	task automatic pulse_ev(input logic [4:0] e);
		@(negedge clk);
		ev = e;
		@(negedge clk);
		ev = 5'h00;
		@(negedge clk);
	endtask

	task automatic width(input logic lvl, output logic [7:0] w);
		w = 8'h00;
		while (pin === lvl && w < 8'd40)
		begin
			w++;
			@(negedge clk);
		end
	endtask

	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// =====
	// Main sequence
	initial
	begin
		failures = 0;
		compares = 0;
		nrst = 1'b0;
		ev = 5'h00;
		// Counting rising edges avoids the start-up edge of the clock
		repeat (2) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		chk1(pin, 1'b1);
		host.rd(`AAI_ADDR_CFG, d);
		chk8(d, 8'h00);
		host.rd(`AAI_ADDR_MASK, d);
		chk8(d, 8'hFF);
		host.rd(`AAI_ADDR_LATCH, d);
		chk8(d, 8'h00);
		host.rd(8'h40, d);
		chk8(d, 8'h00);
		foreach (rows[i])
		begin
			host.wr(`AAI_ADDR_CFG, rows[i].cfg);
			host.wr(`AAI_ADDR_MASK, rows[i].mask);
			host.rd(`AAI_ADDR_CFG, d);
			chk8(d, rows[i].cfg);
			pulse_ev(rows[i].ev);
			chk1(pin, rows[i].pin);
			host.rd(`AAI_ADDR_LATCH, d);
			chk8(d, rows[i].latch);
			@(negedge clk);
			chk1(pin, ~rows[i].cfg[7]);
		end
		// Event in the same cycle as the clearing read
		host.wr(`AAI_ADDR_CFG, 8'h00);
		host.wr(`AAI_ADDR_MASK, 8'h07);
		fork
			host.rd(`AAI_ADDR_LATCH, d);
			pulse_ev(5'h04);
		join
		chk8(d, 8'h00);
		host.rd(`AAI_ADDR_LATCH, d);
		chk8(d, 8'h20);
		// Single pulse, then idle while still latched
		host.wr(`AAI_ADDR_CFG, 8'h60);
		pulse_ev(5'h01);
		width(1'b0, n);
		chk8(n, 8'd8);
		repeat (4) @(negedge clk);
		chk1(pin, 1'b1);
		host.rd(`AAI_ADDR_LATCH, d);
		chk8(d, 8'h08);
		// Repeating pulse while latched
		host.wr(`AAI_ADDR_CFG, 8'h40);
		pulse_ev(5'h02);
		width(1'b0, n);
		chk8(n, 8'd8);
		width(1'b1, n);
		chk8(n, 8'd8);
		chk1(pin, 1'b0);
		host.rd(`AAI_ADDR_LATCH, d);
		chk8(d, 8'h10);
		// Reserved mode keeps the pin idle with an unmasked latch
		host.wr(`AAI_ADDR_CFG, 8'h20);
		pulse_ev(5'h10);
		repeat (4) @(negedge clk);
		chk1(pin, 1'b1);
		// Reset in mid-run, state away from its reset values
		host.wr(`AAI_ADDR_MASK, 8'h57);
		host.rd(`AAI_ADDR_MASK, d);
		chk8(d, 8'h57);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		chk1(pin, 1'b1);
		host.rd(`AAI_ADDR_LATCH, d);
		chk8(d, 8'h00);
		host.rd(`AAI_ADDR_CFG, d);
		chk8(d, 8'h00);
		host.rd(`AAI_ADDR_MASK, d);
		chk8(d, 8'hFF);
		complete_run();
	end
endmodule

`default_nettype wire
